// file: core/tsi_i2c_slave.sv
`timescale 1ns/100ps
module tsi_i2c_slave #(
    parameter bit         USE_ADDR_PINS = 1'b1,
    parameter logic [2:0] FACTORY_ADDR  = tsi_pkg::FACTORY_ADDR_DEF
) (
    // system clock domain
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic [15:0] TEMP_DATA,
    input  wire logic        TEMP_LOAD,
    output logic      [7:0]  CONFIG_OUT,
    // alert pin, open drain
    output logic             ALERT_O,
    output logic             ALERT_OE,
    // two-wire link
    input  wire logic        LINK_CLK,
    input  wire logic        SCL,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    output logic             BUS_BUSY,
    // address select pins
    input  wire logic        ADDR_PIN_2,
    input  wire logic        ADDR_PIN_1,
    input  wire logic        ADDR_PIN_0
);

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] temp;
        logic [7:0]  cfg;
        logic [15:0] hyst;
        logic [15:0] limit;
        logic        alert;
        logic        lo;
    } tsi_sys_type;

    typedef struct packed {
        tsi_pkg::tsi_state_type st;
        logic [3:0]             cnt;
        logic [7:0]             sh;
        logic [7:0]             hi;
        logic                   rd;
        logic                   ptr_ph;
        logic [1:0]             ptr;
        logic                   bidx;
        logic                   mack;
        logic                   oe;
        logic                   busy;
        logic                   pend;
        logic [1:0]             widx;
        logic [15:0]            wval;
        logic [55:0]            snap;
        logic                   scl_p;
        logic                   sda_p;
        logic                   lo;
    } tsi_link_type;

    localparam tsi_sys_type SYS_RST = '{
        temp:  tsi_pkg::TEMP_RST,
        cfg:   tsi_pkg::CFG_RST,
        hyst:  tsi_pkg::HYST_RST,
        limit: tsi_pkg::LIMIT_RST,
        default: '0
    };

    localparam tsi_link_type LINK_RST = '{
        st:    tsi_pkg::ST_IDLE,
        ptr:   tsi_pkg::PTR_RST,
        scl_p: 1'b1,
        sda_p: 1'b1,
        default: '0
    };

    tsi_sys_type  s_q;
    tsi_sys_type  s_d;
    tsi_link_type l_q;
    tsi_link_type l_d;

    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    logic [4:0]  pin_s;
    logic        scl_s;
    logic        sda_s;
    logic [6:0]  own_addr;
    logic        wr_ready;
    logic        wr_valid;
    logic        wr_take;
    logic [17:0] wr_word;
    logic        snap_ready;
    logic        snap_valid;
    logic [55:0] snap_data;

    tsi_sync #(
        .W (5)
    ) u_pins (
        .clk (LINK_CLK),
        .rst (RST),
        .d   ({SCL, SDA_I, ADDR_PIN_2, ADDR_PIN_1, ADDR_PIN_0}),
        .q   (pin_s)
    );

    assign scl_s = pin_s[4];
    assign sda_s = pin_s[3];

    // pins are straps but may be rewired live, hence synchronised
    assign own_addr = {tsi_pkg::ADDR_FIXED,
                       USE_ADDR_PINS ? pin_s[2:0] : FACTORY_ADDR};

    // register writes travel from the link to the system clock
    tsi_xfer #(
        .W (18)
    ) u_wr (
        .src_clk   (LINK_CLK),
        .rst       (RST),
        .src_valid (l_q.pend),
        .src_data  ({l_q.widx, l_q.wval}),
        .src_ready (wr_ready),
        .dst_clk   (CLK_SYS),
        .dst_valid (wr_valid),
        .dst_data  (wr_word)
    );

    assign wr_take = l_q.pend & wr_ready;

    // register image is resent endlessly; reads see a recent copy
    tsi_xfer #(
        .W (56)
    ) u_snap (
        .src_clk   (CLK_SYS),
        .rst       (RST),
        .src_valid (snap_ready),
        .src_data  ({s_q.temp, s_q.cfg, s_q.hyst, s_q.limit}),
        .src_ready (snap_ready),
        .dst_clk   (LINK_CLK),
        .dst_valid (snap_valid),
        .dst_data  (snap_data)
    );

    // ------------------------------------------------------------
    // system domain: registers and alert comparator
    // ------------------------------------------------------------
    always_comb begin
        s_d    = s_q;
        s_d.lo = 1'b0;
        if (wr_valid) begin
            unique case (wr_word[17:16])
                tsi_pkg::PTR_TEMP: begin
                    s_d.temp = s_q.temp;
                end
                tsi_pkg::PTR_CFG: begin
                    s_d.cfg = wr_word[7:0];
                end
                tsi_pkg::PTR_HYST: begin
                    s_d.hyst = wr_word[15:0];
                end
                tsi_pkg::PTR_LIMIT: begin
                    s_d.limit = wr_word[15:0];
                end
            endcase
        end
        // loaded last so a refused bus write never masks a new sample
        if (TEMP_LOAD) begin
            s_d.temp = TEMP_DATA;
        end
        // hysteresis keeps the pin from chattering at the limit
        if ($signed(s_q.temp) > $signed(s_q.limit)) begin
            s_d.alert = 1'b1;
        end else if ($signed(s_q.temp) <= $signed(s_q.hyst)) begin
            s_d.alert = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s_q <= SYS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // link domain: slave protocol engine
    // ------------------------------------------------------------
    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign rise  = scl_s & ~l_q.scl_p;
    assign fall  = ~scl_s & l_q.scl_p;
    assign start = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
    assign stop  = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;

    always_comb begin
        logic [15:0] word;
        logic [7:0]  nxt;
        word      = 16'h0000;
        nxt       = 8'h00;
        l_d       = l_q;
        l_d.lo    = 1'b0;
        l_d.scl_p = scl_s;
        l_d.sda_p = sda_s;
        if (wr_take) begin
            l_d.pend = 1'b0;
        end
        if (snap_valid) begin
            l_d.snap = snap_data;
        end
        unique case (l_q.ptr)
            tsi_pkg::PTR_TEMP: begin
                word = l_q.snap[55:40];
            end
            tsi_pkg::PTR_CFG: begin
                word = {l_q.snap[39:32], l_q.snap[39:32]};
            end
            tsi_pkg::PTR_HYST: begin
                word = l_q.snap[31:16];
            end
            tsi_pkg::PTR_LIMIT: begin
                word = l_q.snap[15:0];
            end
        endcase
        // low byte is frozen with the high byte so a word never tears
        nxt = l_q.bidx ? l_q.hi : word[15:8];
        // only the data line is ever driven, never the clock
        if (stop) begin
            l_d.st   = tsi_pkg::ST_IDLE;
            l_d.oe   = 1'b0;
            l_d.busy = 1'b0;
        end else if (start) begin
            l_d.st     = tsi_pkg::ST_ADDR;
            l_d.cnt    = 4'h0;
            l_d.oe     = 1'b0;
            l_d.busy   = 1'b1;
            l_d.ptr_ph = 1'b1;
            l_d.bidx   = 1'b0;
        end else begin
            unique case (l_q.st)
                tsi_pkg::ST_IDLE: begin
                    l_d.oe = 1'b0;
                end
                tsi_pkg::ST_IGNORE: begin
                    l_d.oe = 1'b0;
                end
                tsi_pkg::ST_ADDR: begin
                    if (rise) begin
                        l_d.sh  = {l_q.sh[6:0], sda_s};
                        l_d.cnt = l_q.cnt + 4'h1;
                    end else if (fall && (l_q.cnt == tsi_pkg::BIT_LAST)) begin
                        if (l_q.sh[7:1] == own_addr) begin
                            l_d.oe = 1'b1;
                            l_d.rd = l_q.sh[0];
                            l_d.st = tsi_pkg::ST_ADDR_ACK;
                        end else begin
                            l_d.st = tsi_pkg::ST_IGNORE;
                        end
                    end
                end
                tsi_pkg::ST_ADDR_ACK: begin
                    if (fall) begin
                        l_d.cnt = 4'h0;
                        if (l_q.rd) begin
                            l_d.sh   = nxt;
                            l_d.hi   = word[7:0];
                            l_d.bidx = 1'b1;
                            l_d.oe   = ~nxt[7];
                            l_d.st   = tsi_pkg::ST_TX;
                        end else begin
                            l_d.oe = 1'b0;
                            l_d.st = tsi_pkg::ST_RX;
                        end
                    end
                end
                tsi_pkg::ST_RX: begin
                    if (rise) begin
                        l_d.sh  = {l_q.sh[6:0], sda_s};
                        l_d.cnt = l_q.cnt + 4'h1;
                    end else if (fall && (l_q.cnt == tsi_pkg::BIT_LAST)) begin
                        l_d.oe = 1'b1;
                        l_d.st = tsi_pkg::ST_RX_ACK;
                        if (l_q.ptr_ph) begin
                            l_d.ptr    = l_q.sh[1:0];
                            l_d.ptr_ph = 1'b0;
                        end else if (l_q.ptr == tsi_pkg::PTR_CFG) begin
                            l_d.pend = 1'b1;
                            l_d.widx = l_q.ptr;
                            l_d.wval = {8'h00, l_q.sh};
                        end else if (!l_q.bidx) begin
                            l_d.hi   = l_q.sh;
                            l_d.bidx = 1'b1;
                        end else begin
                            l_d.pend = 1'b1;
                            l_d.widx = l_q.ptr;
                            l_d.wval = {l_q.hi, l_q.sh};
                            l_d.bidx = 1'b0;
                        end
                    end
                end
                tsi_pkg::ST_RX_ACK: begin
                    if (fall) begin
                        l_d.oe  = 1'b0;
                        l_d.cnt = 4'h0;
                        l_d.st  = tsi_pkg::ST_RX;
                    end
                end
                tsi_pkg::ST_TX: begin
                    if (fall) begin
                        l_d.cnt = l_q.cnt + 4'h1;
                        if (l_q.cnt == tsi_pkg::BIT_TX_LAST) begin
                            l_d.oe = 1'b0;
                            l_d.st = tsi_pkg::ST_TX_ACK;
                        end else begin
                            l_d.sh = {l_q.sh[6:0], 1'b0};
                            l_d.oe = ~l_q.sh[6];
                        end
                    end
                end
                tsi_pkg::ST_TX_ACK: begin
                    if (rise) begin
                        l_d.mack = ~sda_s;
                    end else if (fall) begin
                        l_d.cnt = 4'h0;
                        if (l_q.mack) begin
                            l_d.sh   = nxt;
                            l_d.bidx = ~l_q.bidx;
                            l_d.oe   = ~nxt[7];
                            l_d.st   = tsi_pkg::ST_TX;
                            if (!l_q.bidx) begin
                                l_d.hi = word[7:0];
                            end
                        end else begin
                            l_d.oe = 1'b0;
                            l_d.st = tsi_pkg::ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            l_q <= LINK_RST;
        end else begin
            l_q <= l_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign CONFIG_OUT = s_q.cfg;
    assign ALERT_O    = s_q.lo;
    assign ALERT_OE   = s_q.alert;
    assign SDA_O      = l_q.lo;
    assign SDA_OE     = l_q.oe;
    assign BUS_BUSY   = l_q.busy;

endmodule : tsi_i2c_slave

// file: core/tsi_sync.sv
`timescale 1ns/100ps
module tsi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } tsi_sync_type;

    tsi_sync_type s_q;
    tsi_sync_type s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d      = s_q;
        s_d.meta = d;
        s_d.held = s_q.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.held;

endmodule : tsi_sync

// file: core/tsi_xfer.sv
`timescale 1ns/100ps
module tsi_xfer #(
    parameter int W = 8
) (
    // source side
    input  wire logic         src_clk,
    input  wire logic         rst,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_ready,
    // destination side
    input  wire logic         dst_clk,
    output logic              dst_valid,
    output logic      [W-1:0] dst_data
);

    typedef struct packed {
        logic         req;
        logic         ack_m;
        logic         ack_s;
        logic [W-1:0] data;
    } tsi_src_type;

    typedef struct packed {
        logic         req_m;
        logic         req_s;
        logic         req_p;
        logic         valid;
        logic [W-1:0] data;
    } tsi_dst_type;

    tsi_src_type s_q;
    tsi_src_type s_d;
    tsi_dst_type t_q;
    tsi_dst_type t_d;

    // ------------------------------------------------------------
    // source: toggle request, hold word until acknowledged
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.ack_m = t_q.req_p;
        s_d.ack_s = s_q.ack_m;
        if (src_valid && (s_q.req == s_q.ack_s)) begin
            s_d.req  = ~s_q.req;
            s_d.data = src_data;
        end
    end

    always_ff @(posedge src_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign src_ready = (s_q.req == s_q.ack_s);

    // ------------------------------------------------------------
    // destination: word is stable by the time the toggle arrives
    // ------------------------------------------------------------
    always_comb begin
        t_d       = t_q;
        t_d.req_m = s_q.req;
        t_d.req_s = t_q.req_m;
        t_d.req_p = t_q.req_s;
        t_d.valid = t_q.req_s ^ t_q.req_p;
        if (t_q.req_s ^ t_q.req_p) begin
            t_d.data = s_q.data;
        end
    end

    always_ff @(posedge dst_clk or posedge rst) begin
        if (rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign dst_valid = t_q.valid;
    assign dst_data  = t_q.data;

endmodule : tsi_xfer

// file: pkg/tsi_pkg.sv
package tsi_pkg;

    // ------------------------------------------------------------
    // address and framing
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_FIXED       = 4'h9;
    localparam logic [2:0]  FACTORY_ADDR_DEF = 3'h0;
    localparam logic [3:0]  BIT_LAST         = 4'h8;
    localparam logic [3:0]  BIT_TX_LAST      = 4'h7;

    // ------------------------------------------------------------
    // register pointer codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  PTR_TEMP  = 2'h0;
    localparam logic [1:0]  PTR_CFG   = 2'h1;
    localparam logic [1:0]  PTR_HYST  = 2'h2;
    localparam logic [1:0]  PTR_LIMIT = 2'h3;
    localparam logic [1:0]  PTR_RST   = 2'h0;
    localparam logic [15:0] TEMP_RST  = 16'h0000;
    localparam logic [15:0] HYST_RST  = 16'h4b00;
    localparam logic [15:0] LIMIT_RST = 16'h5000;
    localparam logic [7:0]  CFG_RST   = 8'h00;

    // ------------------------------------------------------------
    // slave states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_RX       = 3'h2,
        ST_RX_ACK   = 3'h6,
        ST_TX       = 3'h7,
        ST_TX_ACK   = 3'h5,
        ST_IGNORE   = 3'h4
    } tsi_state_type;

endpackage : tsi_pkg

// file: sim/test_temp_sensor_i2c_slave.sv
`timescale 1ns/100ps
module test_temp_sensor_i2c_slave;
    logic        clk_sys;
    logic        link_clk;
    logic        rst;
    logic [15:0] temp_data;
    logic        temp_load;
    logic [2:0]  pins;
    logic        scl;
    logic        m_pull;
    wire         sda_line;
    logic [7:0]  config_out;
    logic        alert_o;
    logic        alert_oe;
    logic        sda_o;
    logic        sda_oe;
    logic        bus_busy;
    int          error_cnt;
    int          num_checks;

    assign sda_line = (m_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    tsi_i2c_slave u_dut (
        .CLK_SYS(clk_sys), .RST(rst), .TEMP_DATA(temp_data), .TEMP_LOAD(temp_load),
        .CONFIG_OUT(config_out), .ALERT_O(alert_o), .ALERT_OE(alert_oe), .LINK_CLK(link_clk),
        .SCL(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe), .BUS_BUSY(bus_busy),
        .ADDR_PIN_2(pins[2]), .ADDR_PIN_1(pins[1]), .ADDR_PIN_0(pins[0]));
    tsi_master_model u_master (.clk(clk_sys), .sda(sda_line), .scl(scl), .sda_pull(m_pull));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end
    // offset shifts link edges, though every fifth link edge still lands on a system edge
    initial begin
        link_clk = 1'b0;
        #2;
        forever #24 link_clk = !link_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        u_master.write_byte(b, a);
        check({15'h0, a}, {15'h0, exp_ack});
    endtask : send
    task automatic recv(input logic last, input logic [7:0] exp);
        logic [7:0] d;
        u_master.read_byte(last, d);
        check({8'h0, d}, {8'h0, exp});
    endtask : recv
    task automatic wait_sys(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_sys
    task automatic load_temp(input logic [15:0] v);
        @(posedge clk_sys);
        temp_data <= v;
        temp_load <= 1'b1;
        @(posedge clk_sys);
        temp_load <= 1'b0;
    endtask : load_temp
    task automatic write_reg(input logic [7:0] ptr, input logic [15:0] v, input int n);
        u_master.start_cond;
        send(8'h90, 1'b1);
        send(ptr, 1'b1);
        for (int k = 0; k < n; k++) begin
            send(v[15 - 8 * k -: 8], 1'b1);
        end
        u_master.stop_cond;
    endtask : write_reg

    task automatic t_write_read;
        write_reg(8'h03, 16'h1900, 2);
        check({15'h0, bus_busy}, 16'h0000);
        wait_sys(200);
        u_master.start_cond;
        send(8'h91, 1'b1);
        check({15'h0, bus_busy}, 16'h0001);
        recv(1'b0, 8'h19);
        recv(1'b0, 8'h00);
        recv(1'b1, 8'h19);
        check({15'h0, sda_oe}, 16'h0000);
        u_master.stop_cond;
        $display("test write_read done");
    endtask : t_write_read
    task automatic t_mismatch;
        u_master.start_cond;
        send(8'h92, 1'b0);
        send(8'h01, 1'b0);
        u_master.stop_cond;
        u_master.start_cond;
        send(8'ha0, 1'b0);
        u_master.stop_cond;
        u_master.start_cond;
        send(8'h91, 1'b1);
        recv(1'b1, 8'h19);
        u_master.stop_cond;
        $display("test mismatch done");
    endtask : t_mismatch
    task automatic t_pins;
        for (int i = 0; i < 8; i++) begin
            pins <= 3'(i);
            wait_sys(20);
            u_master.start_cond;
            send({4'h9, 3'(i), 1'b0}, 1'b1);
            u_master.stop_cond;
            u_master.start_cond;
            send({4'h9, 3'(i) ^ 3'h5, 1'b0}, 1'b0);
            u_master.stop_cond;
        end
        pins <= 3'h0;
        wait_sys(20);
        $display("test pins done");
    endtask : t_pins
    task automatic t_registers;
        logic [15:0] exp [4] = '{16'h0c80, 16'h6060, 16'h1800, 16'h1900};
        write_reg(8'h01, 16'h6000, 1);
        write_reg(8'h02, 16'h1800, 2);
        load_temp(16'h0c80);
        // temperature is read only: this write must vanish
        write_reg(8'h00, 16'h1234, 2);
        wait_sys(100);
        check({8'h0, config_out}, 16'h0060);
        for (int p = 0; p < 4; p++) begin
            u_master.start_cond;
            send(8'h90, 1'b1);
            send(8'(p), 1'b1);
            u_master.start_cond;
            send(8'h91, 1'b1);
            recv(1'b0, exp[p][15:8]);
            recv(1'b1, exp[p][7:0]);
            u_master.stop_cond;
        end
        $display("test registers done");
    endtask : t_registers
    task automatic t_abort;
        logic b;
        u_master.start_cond;
        send(8'h90, 1'b1);
        send(8'h03, 1'b1);
        send(8'h7f, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_master.xfer_bit(1'b0, b);
        end
        u_master.start_cond;
        send(8'h91, 1'b1);
        recv(1'b0, 8'h19);
        recv(1'b1, 8'h00);
        u_master.stop_cond;
        $display("test abort done");
    endtask : t_abort
    task automatic t_alert;
        logic [15:0] tv [5] = '{16'h1a00, 16'h1880, 16'h1800, 16'h7ff0, 16'h8000};
        logic        ev [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            load_temp(tv[i]);
            wait_sys(3);
            check({15'h0, alert_oe}, {15'h0, ev[i]});
            check({15'h0, alert_o}, 16'h0000);
        end
        $display("test alert done");
    endtask : t_alert
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        error_cnt  = 0;
        num_checks = 0;
        rst        = 1'b1;
        temp_data  = 16'h0000;
        temp_load  = 1'b0;
        pins       = 3'h0;
        // held across two link edges so both domains see it
        repeat (2) @(posedge link_clk);
        @(posedge clk_sys);
        rst <= 1'b0;
        wait_sys(50);
        check({5'h0, sda_oe, bus_busy, alert_oe, config_out}, 16'h0000);
        $display("test reset done");
        t_write_read;
        t_mismatch;
        t_pins;
        t_registers;
        t_abort;
        t_alert;
        final_report;
    end
    initial begin
        repeat (95000) @(posedge clk_sys);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        final_report;
    end
endmodule : test_temp_sensor_i2c_slave

bind tsi_i2c_slave tsi_i2c_slave_asserts u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .TEMP_DATA(TEMP_DATA), .TEMP_LOAD(TEMP_LOAD),
    .CONFIG_OUT(CONFIG_OUT), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE), .LINK_CLK(LINK_CLK),
    .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .BUS_BUSY(BUS_BUSY),
    .ADDR_PIN_2(ADDR_PIN_2), .ADDR_PIN_1(ADDR_PIN_1), .ADDR_PIN_0(ADDR_PIN_0));

// file: sim/tsi_i2c_slave_asserts.sv
`timescale 1ns/100ps
module tsi_i2c_slave_asserts (
    // system side
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic [15:0] TEMP_DATA,
    input wire logic        TEMP_LOAD,
    input wire logic [7:0]  CONFIG_OUT,
    input wire logic        ALERT_O,
    input wire logic        ALERT_OE,
    // link side
    input wire logic        LINK_CLK,
    input wire logic        SCL,
    input wire logic        SDA_I,
    input wire logic        SDA_O,
    input wire logic        SDA_OE,
    input wire logic        BUS_BUSY,
    input wire logic        ADDR_PIN_2,
    input wire logic        ADDR_PIN_1,
    input wire logic        ADDR_PIN_0
);
    // ------------------------------------------------------------
    // link side
    // ------------------------------------------------------------
    ack_rise_a: assert property (@(posedge LINK_CLK) disable iff (RST)
        $rose(SDA_OE) |-> !SCL) else $error("data pulled while clock high");
    ack_hold_a: assert property (@(posedge LINK_CLK) disable iff (RST)
        $fell(SCL) && $past(SDA_OE, 2) |-> SDA_OE) else $error("pull dropped before fall");
    stop_release_a: assert property (@(posedge LINK_CLK) disable iff (RST)
        SCL && $rose(SDA_I) |-> ##[1:6] (!BUS_BUSY && !SDA_OE))
        else $error("bus not released after stop");
    start_busy_a: assert property (@(posedge LINK_CLK) disable iff (RST)
        SCL && $fell(SDA_I) |-> ##[1:6] BUS_BUSY) else $error("start not seen");
    busy_cause_a: assert property (@(posedge LINK_CLK) disable iff (RST)
        $rose(BUS_BUSY) |-> SCL && !SDA_I) else $error("busy without start");
    sda_drain_a: assert property (@(posedge LINK_CLK) disable iff (RST)
        SDA_OE |-> !SDA_O) else $error("data pin driven high");
    // ------------------------------------------------------------
    // system side; the covers below span both clocks
    // ------------------------------------------------------------
    alert_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        TEMP_LOAD && TEMP_DATA == 16'h7ff0 |-> ##[1:3] ALERT_OE) else $error("alert not set");
    alert_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        TEMP_LOAD && TEMP_DATA == 16'h8000 |-> ##[1:3] !ALERT_OE) else $error("alert stuck");
    alert_drain_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ALERT_OE |-> !ALERT_O) else $error("alert pin driven high");
    reset_idle_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(RST) |-> !SDA_OE && !BUS_BUSY && !ALERT_OE && CONFIG_OUT == 8'h00)
        else $error("outputs not idle after reset");
    cover property (@(posedge LINK_CLK) $rose(SDA_OE));
    cover property (@(posedge LINK_CLK) $fell(BUS_BUSY));
    cover property (@(posedge CLK_SYS) $rose(ALERT_OE));
endmodule : tsi_i2c_slave_asserts

// file: sim/tsi_master_model.sv
`timescale 1ns/100ps
module tsi_master_model (
    // bench clock
    input wire logic clk,
    // two-wire bus, data line pulled up
    input wire logic sda,
    output logic     scl,
    output logic     sda_pull
);
    // third of a bit; keeps each clock phase above five link clocks
    localparam int QTR = 25;
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic qwait(input int n);
        repeat (n * QTR) @(posedge clk);
    endtask : qwait
    // also a repeated start when entered with the clock low
    task automatic start_cond;
        sda_pull <= 1'b0;
        qwait(1);
        scl <= 1'b1;
        qwait(1);
        sda_pull <= 1'b1;
        qwait(2);
        scl <= 1'b0;
        qwait(1);
    endtask : start_cond
    task automatic stop_cond;
        sda_pull <= 1'b1;
        qwait(1);
        scl <= 1'b1;
        qwait(1);
        sda_pull <= 1'b0;
        qwait(2);
    endtask : stop_cond
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull <= !b;
        qwait(1);
        scl <= 1'b1;
        qwait(1);
        r = sda;
        scl <= 1'b0;
        qwait(1);
    endtask : xfer_bit
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = !r;
    endtask : write_byte
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(last, r);
    endtask : read_byte
endmodule : tsi_master_model
